/* verilog/hdpm_cfg.svh */
// Constants of the half-duplex polling master: offsets, fields, resets, timing
//
// Contract
// - After a message, wait acknowledge timeout (20 ms units), then retry or fail.
// - The same timeout limits the wait for a poll response.
// - Hold RTS after the last character for the off delay (20 ms units).
// - After raising RTS, wait the send delay (20 ms units) before transmitting.
// - Characters go out only while CTS is high; the modem raises CTS.
// - With a message pending, wait pre-transmit delay (1 ms units) before RTS.
// - Resend an unacknowledged message up to retry count, then flag undeliverable.
// - Resend an unanswered poll to an active station, then mark it inactive.
// - Priority-poll from first to last address; first address 255 disables it.
// - Normal-poll from first to last address; first address 255 disables it.
// - Each normal visit polls group-size active stations, then back to priority. The code also goes back when the normal range wraps.
// - Stations are 0 to 254; 255 is broadcast, never an individual station.
// - With duplicate detection on, a repeated packet is acknowledged, not executed.
// - After reset or reconfiguration all stations are inactive until they answer.
`ifndef HDPM_CFG_SVH
`define HDPM_CFG_SVH

// ==========================================================================
// Register offsets
`define HDPM_A_CTRL 4'h0
`define HDPM_A_ACKTMO 4'h1
`define HDPM_A_RTSOFF 4'h2
`define HDPM_A_RTSSEND 4'h3
`define HDPM_A_PRETX 4'h4
`define HDPM_A_RETRY 4'h5
`define HDPM_A_PRILO 4'h6
`define HDPM_A_PRIHI 4'h7
`define HDPM_A_NRMLO 4'h8
`define HDPM_A_NRMHI 4'h9
`define HDPM_A_GROUP 4'hA
`define HDPM_A_MASK 4'hB
`define HDPM_A_STATUS 4'hC
`define HDPM_A_ACTSEL 4'hD
`define HDPM_A_ACTIVE 4'hE
`define HDPM_A_STATE 4'hF

// ==========================================================================
// Fields and reset values
`define HDPM_CTRL_EN 0
`define HDPM_CTRL_DUP 1
`define HDPM_EV_MSG_OK 0
`define HDPM_EV_MSG_FAIL 1
`define HDPM_EV_INACTIVE 2
`define HDPM_EV_ACTIVE 3
`define HDPM_EV_DUP 4
`define HDPM_NEV 5
`define HDPM_BCAST 8'hFF
`define HDPM_MAX_STN 8'hFE
`define HDPM_RST_ACKTMO 8'h10
`define HDPM_RST_RETRY 8'h03

// ==========================================================================
// Timing
`define HDPM_CLK_NS 10
`define HDPM_TICK_NS 1000000
`define HDPM_UNIT_MS 20
`define HDPM_TICK_CYC (`HDPM_TICK_NS / `HDPM_CLK_NS)

`endif

/* verilog/hdpm_pkg.sv */
// Types of the half-duplex polling master
`default_nettype none
package hdpm_pkg;

	typedef enum logic [2:0] {
		HDPM_IDLE = 3'b000,
		HDPM_PRE = 3'b001,
		HDPM_RTSW = 3'b010,
		HDPM_SEND = 3'b011,
		HDPM_RTSO = 3'b100,
		HDPM_WAIT = 3'b101
	} hdpm_state_t;

	typedef struct packed {
		hdpm_state_t st;
		logic en;
		logic dup;
		logic [7:0] ack_tmo;
		logic [7:0] rts_off;
		logic [7:0] rts_send;
		logic [7:0] pre_tx;
		logic [7:0] retries;
		logic [7:0] pri_lo;
		logic [7:0] pri_hi;
		logic [7:0] nrm_lo;
		logic [7:0] nrm_hi;
		logic [7:0] grp;
		logic [4:0] mask;
		logic [4:0] sts;
		logic [7:0] act_sel;
		logic [254:0] active;
		logic [7:0] pri_ptr;
		logic [7:0] nrm_ptr;
		logic in_nrm;
		logic [7:0] grp_cnt;
		logic is_msg;
		logic [7:0] cur;
		logic [7:0] tries;
		logic msg_busy;
		logic [7:0] msg_addr;
		logic last_ok;
		logic [7:0] last_addr;
		logic [15:0] last_sig;
		logic rts;
		logic tx_start;
		logic msg_ok;
		logic msg_fail;
		logic ack_send;
		logic exec;
		logic [15:0] rdata;
	} hdpm_reg_t;

endpackage : hdpm_pkg
`default_nettype wire

/* verilog/hdpm_tick.sv */
// One-cycle pulse every millisecond from the core clock
`timescale 1ns/100ps
`default_nettype none
module hdpm_tick #(
	parameter int unsigned CYC = 100000
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	output logic tick_out
);
	logic [31:0] cnt;
	logic [31:0] next_cnt;

	always_comb
	begin
		next_cnt = (cnt == CYC - 1) ? 32'h0000_0000 : cnt + 32'h0000_0001;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			cnt <= 32'h0000_0000;
		else
			cnt <= next_cnt;
	end

	assign tick_out = (cnt == CYC - 1);
endmodule : hdpm_tick
`default_nettype wire

/* verilog/hdpm_ms_timer.sv */
// Millisecond down-counter used for every delay and timeout
`timescale 1ns/100ps
`default_nettype none
module hdpm_ms_timer (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic tick_in,
	input wire logic load_in,
	input wire logic [15:0] ms_in,
	output logic done_out
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;

	// Tick phase is free running, so a load of n lasts between n-1 and n ms
	always_comb
	begin
		next_cnt = cnt;
		if (load_in)
			next_cnt = ms_in;
		else if (tick_in && cnt != 16'h0000)
			next_cnt = cnt - 16'h0001;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			cnt <= 16'h0000;
		else
			cnt <= next_cnt;
	end

	assign done_out = (cnt == 16'h0000);
endmodule : hdpm_ms_timer
`default_nettype wire

/* verilog/hdpm_master.sv */
// Half-duplex polling master: poll scan, message delivery, modem handshake
`timescale 1ns/100ps
`default_nettype none
`include "hdpm_cfg.svh"
module hdpm_master import hdpm_pkg::*; #(
	parameter int unsigned TICK_CYC = `HDPM_TICK_CYC
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	output logic irq_out,
	input wire logic msg_req_in,
	input wire logic [7:0] msg_addr_in,
	output logic msg_busy_out,
	output logic msg_ok_out,
	output logic msg_fail_out,
	output logic rts_out,
	input wire logic cts_in,
	output logic tx_start_out,
	output logic tx_poll_out,
	output logic [7:0] tx_addr_out,
	output logic tx_ok_out,
	input wire logic tx_done_in,
	input wire logic rx_pkt_in,
	input wire logic [7:0] rx_addr_in,
	input wire logic [15:0] rx_sig_in,
	input wire logic rx_ack_in,
	output logic ack_send_out,
	output logic exec_out
);

	// ==========================================================================
	// Helpers
	function automatic logic [15:0] units20(input logic [7:0] v);
		units20 = 16'(v) * 16'(`HDPM_UNIT_MS);
	endfunction : units20

	function automatic logic [7:0] top_of(input logic [7:0] hi);
		top_of = (hi > `HDPM_MAX_STN) ? `HDPM_MAX_STN : hi;
	endfunction : top_of

	function automatic logic [7:0] clamp(input logic [7:0] p, input logic [7:0] lo, input logic [7:0] hi);
		clamp = (p < lo || p > top_of(hi)) ? lo : p;
	endfunction : clamp

	// ==========================================================================
	// Timebase
	logic tick;
	logic tmr_load;
	logic [15:0] tmr_ms;
	logic tmr_done;

	hdpm_tick #(
		.CYC(TICK_CYC)
	) u_tick (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.tick_out(tick)
	);

	hdpm_ms_timer u_tmr (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.tick_in(tick),
		.load_in(tmr_load),
		.ms_in(tmr_ms),
		.done_out(tmr_done)
	);

	// ==========================================================================
	// State
	hdpm_reg_t s;
	hdpm_reg_t n;
	logic [4:0] ev;
	logic pri_on;
	logic nrm_on;
	logic adv;
	logic alive;
	logic resp;
	logic wrap;
	logic [7:0] cnt;

	always_comb
	begin
		n = s;
		ev = 5'h00;
		tmr_load = 1'b0;
		tmr_ms = 16'h0000;
		adv = 1'b0;
		alive = 1'b0;
		wrap = 1'b0;
		cnt = 8'h00;
		n.tx_start = 1'b0;
		n.msg_ok = 1'b0;
		n.msg_fail = 1'b0;
		n.ack_send = 1'b0;
		n.exec = 1'b0;
		pri_on = (s.pri_lo != `HDPM_BCAST);
		nrm_on = (s.nrm_lo != `HDPM_BCAST);

		// ======================================================================
		// Register writes; a write to any offset up to the group size restarts discovery
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				`HDPM_A_CTRL:
				begin
					n.en = reg_wdata_in[`HDPM_CTRL_EN];
					n.dup = reg_wdata_in[`HDPM_CTRL_DUP];
				end
				`HDPM_A_ACKTMO: n.ack_tmo = reg_wdata_in[7:0];
				`HDPM_A_RTSOFF: n.rts_off = reg_wdata_in[7:0];
				`HDPM_A_RTSSEND: n.rts_send = reg_wdata_in[7:0];
				`HDPM_A_PRETX: n.pre_tx = reg_wdata_in[7:0];
				`HDPM_A_RETRY: n.retries = reg_wdata_in[7:0];
				`HDPM_A_PRILO: n.pri_lo = reg_wdata_in[7:0];
				`HDPM_A_PRIHI: n.pri_hi = reg_wdata_in[7:0];
				`HDPM_A_NRMLO: n.nrm_lo = reg_wdata_in[7:0];
				`HDPM_A_NRMHI: n.nrm_hi = reg_wdata_in[7:0];
				`HDPM_A_GROUP: n.grp = reg_wdata_in[7:0];
				`HDPM_A_MASK: n.mask = reg_wdata_in[4:0];
				`HDPM_A_ACTSEL: n.act_sel = reg_wdata_in[7:0];
				default: ;
			endcase
			if (reg_addr_in <= `HDPM_A_GROUP)
			begin
				n.active = '0;
				n.in_nrm = 1'b0;
				n.grp_cnt = 8'h00;
			end
		end

		// ======================================================================
		// Register reads, data valid from the following cycle until the next read
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				`HDPM_A_CTRL: n.rdata = {14'h0000, s.dup, s.en};
				`HDPM_A_ACKTMO: n.rdata = {8'h00, s.ack_tmo};
				`HDPM_A_RTSOFF: n.rdata = {8'h00, s.rts_off};
				`HDPM_A_RTSSEND: n.rdata = {8'h00, s.rts_send};
				`HDPM_A_PRETX: n.rdata = {8'h00, s.pre_tx};
				`HDPM_A_RETRY: n.rdata = {8'h00, s.retries};
				`HDPM_A_PRILO: n.rdata = {8'h00, s.pri_lo};
				`HDPM_A_PRIHI: n.rdata = {8'h00, s.pri_hi};
				`HDPM_A_NRMLO: n.rdata = {8'h00, s.nrm_lo};
				`HDPM_A_NRMHI: n.rdata = {8'h00, s.nrm_hi};
				`HDPM_A_GROUP: n.rdata = {8'h00, s.grp};
				`HDPM_A_MASK: n.rdata = {11'h000, s.mask};
				`HDPM_A_STATUS: n.rdata = {11'h000, s.sts};
				`HDPM_A_ACTSEL: n.rdata = {8'h00, s.act_sel};
				`HDPM_A_ACTIVE:
					n.rdata = {15'h0000, (s.act_sel <= `HDPM_MAX_STN) ? s.active[s.act_sel] : 1'b0};
				default: n.rdata = {3'h0, s.msg_busy, s.in_nrm, s.rts, 7'h00, s.st};
			endcase
		end

		// ======================================================================
		// Incoming packets: acknowledge, drop duplicates, never from broadcast
		if (rx_pkt_in && rx_addr_in != `HDPM_BCAST)
		begin
			n.ack_send = 1'b1;
			n.last_ok = 1'b1;
			n.last_addr = rx_addr_in;
			n.last_sig = rx_sig_in;
			if (s.dup && s.last_ok && s.last_addr == rx_addr_in && s.last_sig == rx_sig_in)
				ev[`HDPM_EV_DUP] = 1'b1;
			else
				n.exec = 1'b1;
		end
		if (msg_req_in && !s.msg_busy && msg_addr_in != `HDPM_BCAST)
		begin
			n.msg_busy = 1'b1;
			n.msg_addr = msg_addr_in;
		end

		// A poll is answered by any packet from the polled station
		resp = s.is_msg ? (rx_ack_in && rx_addr_in == s.cur)
			: (rx_pkt_in && rx_addr_in == s.cur);

		// ======================================================================
		// Link sequencer
		case (s.st)
			HDPM_IDLE:
			begin
				if (!pri_on)
					n.in_nrm = 1'b1;
				else if (!nrm_on)
					n.in_nrm = 1'b0;
				if (s.en && (s.msg_busy || pri_on || nrm_on))
				begin
					n.tries = 8'h00;
					n.st = HDPM_PRE;
					tmr_load = 1'b1;
					tmr_ms = 16'(s.pre_tx);
					if (s.msg_busy)
					begin
						n.is_msg = 1'b1;
						n.cur = s.msg_addr;
					end
					else if (pri_on && !(s.in_nrm && nrm_on))
					begin
						n.is_msg = 1'b0;
						n.cur = clamp(s.pri_ptr, s.pri_lo, s.pri_hi);
					end
					else
					begin
						n.is_msg = 1'b0;
						n.cur = clamp(s.nrm_ptr, s.nrm_lo, s.nrm_hi);
					end
				end
			end
			HDPM_PRE:
			begin
				if (tmr_done)
				begin
					n.rts = 1'b1;
					n.st = HDPM_RTSW;
					tmr_load = 1'b1;
					tmr_ms = units20(s.rts_send);
				end
			end
			HDPM_RTSW:
			begin
				if (tmr_done)
				begin
					n.tx_start = 1'b1;
					n.st = HDPM_SEND;
				end
			end
			HDPM_SEND:
			begin
				if (tx_done_in)
				begin
					n.st = HDPM_RTSO;
					tmr_load = 1'b1;
					tmr_ms = units20(s.rts_off);
				end
			end
			HDPM_RTSO, HDPM_WAIT:
			begin
				if (s.st == HDPM_RTSO && tmr_done)
				begin
					n.rts = 1'b0;
					n.st = HDPM_WAIT;
					tmr_load = 1'b1;
					tmr_ms = units20(s.ack_tmo);
				end
				if (resp)
				begin
					n.rts = 1'b0;
					n.st = HDPM_IDLE;
					tmr_load = 1'b0;
					if (s.is_msg)
					begin
						n.msg_busy = 1'b0;
						n.msg_ok = 1'b1;
						ev[`HDPM_EV_MSG_OK] = 1'b1;
					end
					else
					begin
						adv = 1'b1;
						alive = 1'b1;
						n.active[s.cur] = 1'b1;
						if (!s.active[s.cur])
							ev[`HDPM_EV_ACTIVE] = 1'b1;
					end
				end
				else if (s.st == HDPM_WAIT && tmr_done)
				begin
					if (s.tries < s.retries && (s.is_msg || s.active[s.cur]))
					begin
						n.tries = s.tries + 8'h01;
						n.st = HDPM_PRE;
						tmr_load = 1'b1;
						tmr_ms = 16'(s.pre_tx);
					end
					else
					begin
						n.st = HDPM_IDLE;
						if (s.is_msg)
						begin
							n.msg_busy = 1'b0;
							n.msg_fail = 1'b1;
							ev[`HDPM_EV_MSG_FAIL] = 1'b1;
						end
						else
						begin
							adv = 1'b1;
							if (s.active[s.cur])
								ev[`HDPM_EV_INACTIVE] = 1'b1;
							n.active[s.cur] = 1'b0;
						end
					end
				end
			end
			default: n.st = HDPM_IDLE;
		endcase

		// ======================================================================
		// Scan pointers: whole priority range, then one group of the normal range, or fewer where the normal range wraps
		if (adv)
		begin
			if (!s.in_nrm)
			begin
				if (s.cur >= top_of(s.pri_hi))
				begin
					n.pri_ptr = s.pri_lo;
					if (nrm_on && s.grp != 8'h00)
					begin
						n.in_nrm = 1'b1;
						n.grp_cnt = 8'h00;
					end
				end
				else
					n.pri_ptr = s.cur + 8'h01;
			end
			else
			begin
				wrap = (s.cur >= top_of(s.nrm_hi));
				n.nrm_ptr = wrap ? s.nrm_lo : s.cur + 8'h01;
				cnt = s.grp_cnt + 8'(alive);
				n.grp_cnt = cnt;
				// Inactive stations are still tried but do not use up the group
				if (pri_on && (wrap || cnt >= s.grp))
					n.in_nrm = 1'b0;
			end
		end

		// ======================================================================
		// Sticky events; a new event beats the clearing read
		n.sts = ((reg_rd_in && reg_addr_in == `HDPM_A_STATUS) ? 5'h00 : s.sts) | ev;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			s <= '0;
			s.st <= HDPM_IDLE;
			s.ack_tmo <= `HDPM_RST_ACKTMO;
			s.retries <= `HDPM_RST_RETRY;
			s.pri_lo <= `HDPM_BCAST;
			s.pri_hi <= `HDPM_BCAST;
			s.nrm_lo <= `HDPM_BCAST;
			s.nrm_hi <= `HDPM_BCAST;
		end
		else
			s <= n;
	end

	// ==========================================================================
	// Outputs
	assign reg_rdata_out = s.rdata;
	assign irq_out = |(s.sts & s.mask);
	assign msg_busy_out = s.msg_busy;
	assign msg_ok_out = s.msg_ok;
	assign msg_fail_out = s.msg_fail;
	assign rts_out = s.rts;
	assign tx_start_out = s.tx_start;
	assign tx_poll_out = !s.is_msg;
	assign tx_addr_out = s.cur;
	assign tx_ok_out = (s.st == HDPM_SEND) && cts_in;
	assign ack_send_out = s.ack_send;
	assign exec_out = s.exec;

endmodule : hdpm_master
`default_nettype wire

/* sim/hdpm_properties.sv */
// Port assertions for the half-duplex polling master
`timescale 1ns/100ps
`default_nettype none
module hdpm_properties (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic msg_req_in,
	input wire logic [7:0] msg_addr_in,
	input wire logic msg_busy_out,
	input wire logic msg_ok_out,
	input wire logic msg_fail_out,
	input wire logic rts_out,
	input wire logic cts_in,
	input wire logic tx_start_out,
	input wire logic tx_ok_out,
	input wire logic rx_pkt_in,
	input wire logic [7:0] rx_addr_in,
	input wire logic ack_send_out,
	input wire logic exec_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	// ==========================================
	// Sequences
	sequence s_lead;
		!tx_start_out ##1 rts_out;
	endsequence
	sequence s_hold;
		rts_out [*2];
	endsequence
	// ==========================================
	// Properties
	cts_gate_a: assert property (tx_ok_out |-> cts_in && rts_out) else $error("char sent without clear");
	send_lead_a: assert property ($rose(rts_out) |-> s_lead) else $error("start too soon after rts");
	off_hold_a: assert property (tx_start_out |=> s_hold) else $error("rts dropped while sending");
	ack_rx_a: assert property (rx_pkt_in && rx_addr_in != 8'hFF |=> ack_send_out) else $error("no ack");
	bcast_silent_a: assert property (rx_pkt_in && rx_addr_in == 8'hFF |=> !ack_send_out) else $error("bcast ack");
	// Execution only ever follows a packet taken in the cycle before
	exec_ack_a: assert property (exec_out |-> ack_send_out && $past(rx_pkt_in)) else $error("exec without ack");
	req_take_a: assert property (msg_req_in && !msg_busy_out && msg_addr_in != 8'hFF |=> msg_busy_out)
		else $error("request not taken");
	msg_end_a: assert property (msg_ok_out || msg_fail_out |-> !msg_busy_out && !(msg_ok_out && msg_fail_out))
		else $error("bad message end");
endmodule : hdpm_properties
bind hdpm_master hdpm_properties u_hdpm_properties (.core_clk_in, .nrst_in, .msg_req_in, .msg_addr_in,
	.msg_busy_out, .msg_ok_out, .msg_fail_out, .rts_out, .cts_in, .tx_start_out, .tx_ok_out, .rx_pkt_in,
	.rx_addr_in, .ack_send_out, .exec_out);
`default_nettype wire

/* sim/hdpm_modem.sv */
// Behavioural modem and slave stations on the far side of the master
`timescale 1ns/100ps
`default_nettype none
module hdpm_modem (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic rts_in,
	input wire logic start_in,
	input wire logic poll_in,
	input wire logic [7:0] addr_in,
	input wire logic ok_in,
	input wire logic [255:0] live_in,
	input wire logic ack_en_in,
	input wire logic inj_in,
	input wire logic [7:0] inj_addr_in,
	input wire logic [15:0] inj_sig_in,
	output logic cts_out,
	output logic done_out,
	output logic pkt_out,
	output logic ack_out,
	output logic [7:0] src_out,
	output logic [15:0] sig_out
);
	logic busy, pend, poll;
	logic [7:0] addr;
	logic [2:0] cnt;
	always @(posedge core_clk_in or negedge nrst_in)
	begin
		done_out <= 1'b0;
		pkt_out <= 1'b0;
		ack_out <= 1'b0;
		// Idle lines keep changing so stale data never looks valid
		src_out <= ~src_out;
		sig_out <= ~sig_out;
		cts_out <= rts_in && ($urandom % 4 != 0);
		if (!nrst_in)
		begin
			cts_out <= 1'b0;
			busy <= 1'b0;
			pend <= 1'b0;
			src_out <= 8'h00;
			sig_out <= 16'h0000;
		end
		else if (start_in)
		begin
			busy <= 1'b1;
			poll <= poll_in;
			addr <= addr_in;
			cnt <= 3'h0;
		end
		else if (busy && ok_in)
		begin
			cnt <= (cnt == 3'h3) ? 3'h0 : cnt + 3'h1;
			busy <= cnt != 3'h3;
			done_out <= cnt == 3'h3;
			pend <= (cnt == 3'h3) && (poll ? live_in[addr] : ack_en_in);
		end
		else if (pend && !rts_in)
		begin
			// Short answer well inside the timeout, only after turnaround
			cnt <= cnt + 3'h1;
			if (cnt == 3'h4)
			begin
				pend <= 1'b0;
				pkt_out <= poll;
				ack_out <= !poll;
				src_out <= addr;
				sig_out <= 16'($urandom);
			end
		end
		else if (inj_in)
		begin
			pkt_out <= 1'b1;
			src_out <= inj_addr_in;
			sig_out <= inj_sig_in;
		end
	end
endmodule : hdpm_modem
`default_nettype wire

/* sim/half_duplex_polling_master_test.sv */
// Self-checking bench for the half-duplex polling master
`timescale 1ns/100ps
`default_nettype none
module half_duplex_polling_master_test;
	localparam int T = 10;
	localparam int U = 20 * T;
	localparam logic [19:0] RV [9] = '{20'h00000, 20'h10010, 20'h50003, 20'h600FF, 20'h700FF, 20'h800FF,
		20'h900FF, 20'hC0000, 20'hE0000};
	localparam logic [19:0] WV [9] = '{20'h10001, 20'h20001, 20'h30001, 20'h40002, 20'h50001, 20'h60002,
		20'h70003, 20'hA0000, 20'h00001};
	logic core_clk_in, nrst_in, reg_wr_in, reg_rd_in, irq_out, msg_req_in, msg_busy_out, msg_ok_out;
	logic msg_fail_out, rts_out, cts_in, tx_start_out, tx_poll_out, tx_ok_out, tx_done_in, rx_pkt_in;
	logic rx_ack_in, ack_send_out, exec_out, ack_en, inj, rts_q, got_rx, rd_d, inb;
	logic [3:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, rx_sig_in, inj_s;
	logic [7:0] msg_addr_in, tx_addr_out, rx_addr_in, inj_a;
	logic [255:0] live;
	logic [15:0] rdq[$];
	logic mq[$], eq[$];
	int n_mismatch, n_tests, lo_a, hi_a, lo_b, hi_b, grp, nrun, cyc, t_rts, t_done, t_rx, n_mtx;
	hdpm_master #(.TICK_CYC(T)) u_hdpm_master (.core_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out, .msg_req_in, .msg_addr_in, .msg_busy_out,
		.msg_ok_out, .msg_fail_out, .rts_out, .cts_in, .tx_start_out, .tx_poll_out, .tx_addr_out,
		.tx_ok_out, .tx_done_in, .rx_pkt_in, .rx_addr_in, .rx_sig_in, .rx_ack_in, .ack_send_out, .exec_out);
	hdpm_modem u_hdpm_modem (.core_clk_in, .nrst_in, .rts_in(rts_out), .start_in(tx_start_out),
		.poll_in(tx_poll_out), .addr_in(tx_addr_out), .ok_in(tx_ok_out), .live_in(live), .ack_en_in(ack_en),
		.inj_in(inj), .inj_addr_in(inj_a), .inj_sig_in(inj_s), .cts_out(cts_in), .done_out(tx_done_in),
		.pkt_out(rx_pkt_in), .ack_out(rx_ack_in), .src_out(rx_addr_in), .sig_out(rx_sig_in));
	// ==========================================
	// Checking and bus tasks
	task chk_val(string nm, logic [31:0] e, logic [31:0] s);
		n_tests++;
		if (e !== s)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk_val
	// Tick phase is free running, so spans carry one tick of slack
	task chk_span(string nm, int e, int s);
		n_tests++;
		if (s < e - T - 2 || s > e + T + 8)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, s);
		end
	endtask : chk_span
	task wr(logic [3:0] a, logic [15:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge core_clk_in);
	endtask : wr
	task rd(logic [3:0] a, logic [15:0] e);
		rdq.push_back(e);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		@(posedge core_clk_in);
	endtask : rd
	task send_msg(logic [7:0] a, logic ok);
		repeat (9000) if (msg_busy_out !== 1'b0) @(posedge core_clk_in);
		mq.push_back(ok);
		msg_addr_in <= a;
		msg_req_in <= 1'b1;
		@(posedge core_clk_in);
		msg_req_in <= 1'b0;
		@(posedge core_clk_in);
		repeat (9000) if (msg_busy_out !== 1'b0) @(posedge core_clk_in);
	endtask : send_msg
	task inj_pkt(logic [7:0] a, logic [15:0] s, logic e);
		if (a != 8'hFF)
			eq.push_back(e);
		inj_a <= a;
		inj_s <= s;
		inj <= 1'b1;
		@(posedge core_clk_in);
		inj <= 1'b0;
		repeat (3) @(posedge core_clk_in);
	endtask : inj_pkt
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// ==========================================
	// Result watchers
	always @(posedge core_clk_in)
	begin
		if (rd_d)
			chk_val("rdata", rdq.pop_front(), reg_rdata_out);
		rd_d <= reg_rd_in;
		if (msg_ok_out || msg_fail_out)
			chk_val("msg_ok", mq.pop_front(), msg_ok_out);
		if (ack_send_out && eq.size() > 0)
			chk_val("exec", eq.pop_front(), exec_out);
	end
	always @(posedge core_clk_in)
	begin
		cyc++;
		rts_q <= rts_out;
		if (rx_pkt_in || rx_ack_in)
		begin
			t_rx = cyc;
			got_rx = 1'b1;
		end
		if (rts_out && !rts_q)
		begin
			if (got_rx)
				chk_span("pre_delay", 2 * T, cyc - t_rx);
			got_rx = 1'b0;
			t_rts = cyc;
		end
		if (tx_done_in)
			t_done = cyc;
		if (!rts_out && rts_q)
			chk_span("off_delay", U, cyc - t_done);
		if (tx_start_out)
			chk_span("send_delay", U, cyc - t_rts);
		if (tx_start_out && !tx_poll_out)
			n_mtx++;
		if (tx_start_out && tx_poll_out)
		begin
			inb = tx_addr_out >= lo_b && tx_addr_out <= hi_b;
			chk_val("poll_addr", 1, inb || (tx_addr_out >= lo_a && tx_addr_out <= hi_a));
			if (inb)
				nrun++;
			else if (nrun > 0)
			begin
				chk_val("group", grp, nrun);
				nrun = 0;
			end
		end
	end
	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	initial
	begin
		#700000;
		n_mismatch++;
		print_verdict();
	end
	// ==========================================
	// Main sequence
	initial
	begin
		{nrst_in, reg_wr_in, reg_rd_in, msg_req_in, inj, rts_q, got_rx, rd_d} = '0;
		{reg_addr_in, reg_wdata_in, msg_addr_in, inj_a, inj_s} = '0;
		ack_en = 1'b1;
		live = 256'h4;
		{lo_a, hi_a, lo_b, hi_b, grp} = {32'd2, 32'd3, 32'd1, 32'd0, 32'd0};
		void'($urandom(32'hCB893D41));
		repeat (3) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		@(posedge core_clk_in);
		foreach (RV[i]) rd(RV[i][19:16], RV[i][15:0]);
		// Answer arrives a few cycles after turnaround, far inside one timeout unit
		foreach (WV[i]) wr(WV[i][19:16], WV[i][15:0]);
		repeat (3000) @(posedge core_clk_in);
		chk_val("irq_masked", 0, irq_out);
		rd(4'hC, 16'h0008);
		wr(4'hD, 16'h0002);
		rd(4'hE, 16'h0001);
		$display("test priority_poll done");
		live <= 256'h0;
		wr(4'hB, 16'h0004);
		repeat (8000) if (irq_out !== 1'b1) @(posedge core_clk_in);
		chk_val("irq", 1, irq_out);
		rd(4'hC, 16'h0004);
		rd(4'hE, 16'h0000);
		chk_val("irq_clear", 0, irq_out);
		$display("test station_loss done");
		live <= 256'hC4;
		grp = 1;
		{lo_b, hi_b} = {32'd6, 32'd7};
		wr(4'hA, 16'h0001);
		wr(4'h9, 16'h0007);
		wr(4'h8, 16'h0006);
		repeat (6000) @(posedge core_clk_in);
		$display("test normal_group done");
		send_msg(8'h02, 1'b1);
		ack_en <= 1'b0;
		n_mtx = 0;
		send_msg(8'h08 + 8'($urandom % 200), 1'b0);
		chk_val("msg_sends", 2, n_mtx);
		msg_addr_in <= 8'hFF;
		msg_req_in <= 1'b1;
		@(posedge core_clk_in);
		msg_req_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		chk_val("busy_bcast", 0, msg_busy_out);
		$display("test messages done");
		wr(4'h6, 16'h00FF);
		// An empty priority range leaves the group size unused
		wr(4'hA, 16'h0000);
		repeat (600) @(posedge core_clk_in);
		{lo_a, hi_a} = {32'd1, 32'd0};
		repeat (3000) @(posedge core_clk_in);
		$display("test priority_off done");
		wr(4'h8, 16'h00FF);
		wr(4'h0, 16'h0003);
		repeat (1500) @(posedge core_clk_in);
		rd(4'hC, 16'h000B);
		rd(4'hF, 16'h0800);
		rd(4'hB, 16'h0004);
		inj_pkt(8'h05, 16'h1234, 1'b1);
		inj_pkt(8'hFF, 16'h1234, 1'b0);
		inj_pkt(8'h05, 16'h1234, 1'b0);
		inj_pkt(8'h05, 16'h1235, 1'b1);
		inj_pkt(8'h06, 16'h1235, 1'b1);
		rd(4'hC, 16'h0010);
		chk_val("acks_left", 0, eq.size());
		chk_val("msgs_left", 0, mq.size());
		$display("test duplicates done");
		print_verdict();
	end
endmodule : half_duplex_polling_master_test
`default_nettype wire
